// >>> rtl/udg_general_cmd_regs.sv
// general command registers: results, wake lock, scratch and frame number
`default_nettype none
module udg_general_cmd_regs (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        cmd_data_select,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    input  wire logic        bus_wide,
    input  wire logic [15:0] bus_din,
    output logic      [15:0] bus_dout,
    output logic             bus_dout_valid,
    input  wire logic        usb_suspend,
    input  wire logic        usb_bus_reset,
    input  wire logic        sof_valid,
    input  wire logic [10:0] sof_frame,
    input  wire logic        txn_done,
    input  wire logic [3:0]  txn_ep,
    input  wire logic        txn_control_ep,
    input  wire logic        txn_iso,
    input  wire logic        txn_data_moved,
    input  wire logic        txn_toggle,
    input  wire logic        txn_pid_seen,
    input  wire logic [7:0]  txn_pid,
    input  wire logic        err_token_crc,
    input  wire logic        err_data_crc,
    input  wire logic        err_timeout,
    input  wire logic        err_babble,
    input  wire logic        err_eop,
    input  wire logic        err_stuff,
    input  wire logic        err_sync,
    input  wire logic        evt_nak,
    input  wire logic        evt_stall,
    input  wire logic        evt_overflow,
    input  wire logic        evt_unexpected,
    input  wire logic        evt_setup,
    input  wire logic        evt_empty_tx,
    input  wire logic        evt_toggle_bad,
    output logic             regs_locked,
    output logic             fifo_write_en,
    output logic             payload_discard
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // fault classification
    // ------------------------------------------------------------
    // first cause in the wire order wins; later stages never see a
    // packet whose framing already failed
    function automatic logic [3:0] fault_code(
        input logic       pid_seen,
        input logic [7:0] pid,
        input logic [13:0] f
    );
        logic [3:0] c;
        c = udg_pkg::F_NONE;
        if (f[0]) begin
            c = udg_pkg::F_SYNC;
        end else if (f[1]) begin
            c = udg_pkg::F_STUFF;
        end else if (pid_seen && (pid[7:4] != ~pid[3:0])) begin
            c = udg_pkg::F_PID_ENC;
        end else if (pid_seen && (pid[3:0] == udg_pkg::PID_UNDEFINED)) begin
            c = udg_pkg::F_PID_UNK;
        end else if (f[2]) begin
            c = udg_pkg::F_TOKEN_CRC;
        end else if (f[3]) begin
            c = udg_pkg::F_DATA_CRC;
        end else if (f[4]) begin
            c = udg_pkg::F_EOP;
        end else if (f[5]) begin
            c = udg_pkg::F_BABBLE;
        end else if (f[6]) begin
            c = udg_pkg::F_OVERFLOW;
        end else if (f[7]) begin
            c = udg_pkg::F_UNEXPECTED;
        end else if (f[8]) begin
            c = udg_pkg::F_TOGGLE;
        end else if (f[9]) begin
            c = udg_pkg::F_TIMEOUT;
        end else if (f[10]) begin
            c = udg_pkg::F_STALL;
        end else if (f[11]) begin
            c = udg_pkg::F_NAK;
        end else if (f[12]) begin
            c = udg_pkg::F_EMPTY_ISO;
        end
        return c;
    endfunction

    logic [13:0] fault_vec;
    logic [3:0]  txn_code;
    assign fault_vec = {
        1'b0,
        evt_empty_tx && txn_iso,
        evt_nak,
        evt_stall,
        err_timeout,
        evt_toggle_bad,
        evt_unexpected || (evt_setup && !txn_control_ep),
        evt_overflow,
        err_babble,
        err_eop,
        err_data_crc,
        err_token_crc,
        err_stuff,
        err_sync
    };
    assign txn_code = fault_code(txn_pid_seen, txn_pid, fault_vec);

    // ------------------------------------------------------------
    // result store
    // ------------------------------------------------------------
    udg_res_if res ();
    udg_result_store u_store (
        .clk   (clk),
        .rst_n (rst_n),
        .res   (res.store)
    );
    assign res.ev_valid  = txn_done;
    assign res.ev_ep     = txn_ep;
    assign res.ev_code   = txn_code;
    assign res.ev_ok     = txn_data_moved && (txn_code == udg_pkg::F_NONE);
    assign res.ev_toggle = txn_toggle;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            payload_discard <= 1'b0;
        end else begin
            payload_discard <= txn_done && (txn_code == udg_pkg::F_TOGGLE);
        end
    end

    // ------------------------------------------------------------
    // command phase tracking
    // ------------------------------------------------------------
    function automatic udg_pkg::udg_phase_type decode_cmd(input logic [7:0] cmd);
        udg_pkg::udg_phase_type p;
        p = udg_pkg::PH_IGNORE;
        if (cmd[7:4] == udg_pkg::CMD_RESULT_HI) begin
            p = udg_pkg::PH_RESULT;
        end else if (cmd == udg_pkg::CMD_UNLOCK) begin
            p = udg_pkg::PH_UNLOCK;
        end else if (cmd == udg_pkg::CMD_SCR_WR) begin
            p = udg_pkg::PH_SCR_WR;
        end else if (cmd == udg_pkg::CMD_SCR_RD) begin
            p = udg_pkg::PH_SCR_RD;
        end else if (cmd == udg_pkg::CMD_FRAME_RD) begin
            p = udg_pkg::PH_FRAME;
        end
        return p;
    endfunction
    udg_pkg::udg_phase_type phase_q;
    logic [3:0]             sel_ep_q;
    logic                   byte_idx_q;
    logic                   lock_q;
    logic                   cmd_wr;
    logic                   data_wr;
    logic                   data_rd;
    logic                   reads_ok;
    assign cmd_wr   = bus_wr && cmd_data_select && !usb_suspend;
    assign data_wr  = bus_wr && !cmd_data_select && !usb_suspend;
    assign data_rd  = bus_rd && !cmd_data_select;
    assign reads_ok = !lock_q && !usb_suspend;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q    <= udg_pkg::PH_IDLE;
            sel_ep_q   <= 4'h0;
            byte_idx_q <= 1'b0;
        end else if (usb_bus_reset) begin
            phase_q    <= udg_pkg::PH_IDLE;
            byte_idx_q <= 1'b0;
        end else if (cmd_wr) begin
            // only the low lane carries the command on a wide bus
            phase_q    <= decode_cmd(bus_din[7:0]);
            sel_ep_q   <= bus_din[3:0];
            byte_idx_q <= 1'b0;
        end else if (data_wr || data_rd) begin
            byte_idx_q <= !byte_idx_q;
        end
    end

    // ------------------------------------------------------------
    // wake lock
    // ------------------------------------------------------------
    logic [7:0] key_low_q;
    logic [7:0] wake_key_low;
    logic [7:0] wake_key_high;
    assign wake_key_low  = udg_pkg::WAKE_KEY[7:0];
    assign wake_key_high = udg_pkg::WAKE_KEY[15:8];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q    <= udg_pkg::LOCK_RST;
            key_low_q <= 8'h00;
        end else if (usb_suspend) begin
            lock_q <= 1'b1;
        end else if (data_wr && (phase_q == udg_pkg::PH_UNLOCK)) begin
            if (bus_wide) begin
                if (bus_din == udg_pkg::WAKE_KEY) begin
                    lock_q <= 1'b0;
                end
            end else if (!byte_idx_q) begin
                key_low_q <= bus_din[7:0];
            end else if ((key_low_q == wake_key_low) && (bus_din[7:0] == wake_key_high)) begin
                lock_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regs_locked   <= udg_pkg::LOCK_RST;
            fifo_write_en <= 1'b0;
        end else begin
            regs_locked   <= lock_q;
            fifo_write_en <= !lock_q && !usb_suspend;
        end
    end

    // ------------------------------------------------------------
    // scratch store
    // ------------------------------------------------------------
    logic [15:0] scratch_q;
    logic        host_wr_ok;
    // locked writes other than the key are dropped
    assign host_wr_ok = data_wr && !lock_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scratch_q <= udg_pkg::SCRATCH_RST;
        end else if (host_wr_ok && (phase_q == udg_pkg::PH_SCR_WR)) begin
            if (bus_wide) begin
                scratch_q <= {1'b0, bus_din[14:0]};
            end else if (!byte_idx_q) begin
                scratch_q[7:0] <= bus_din[7:0];
            end else begin
                scratch_q[14:8] <= bus_din[6:0];
            end
        end
    end

    // ------------------------------------------------------------
    // frame number
    // ------------------------------------------------------------
    logic [10:0] frame_count_q;
    // bus reset leaves the old number; it is meaningless until the next sof
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_count_q <= udg_pkg::FRAME_RST;
        end else if (sof_valid) begin
            frame_count_q <= sof_frame;
        end
    end

    // ------------------------------------------------------------
    // read data path
    // ------------------------------------------------------------
    logic [15:0] scratch_word;
    logic [15:0] frame_word;
    logic [15:0] rd_word;
    logic [7:0]  frame_count_low;
    logic [2:0]  frame_count_high;
    assign frame_count_low  = frame_count_q[7:0];
    assign frame_count_high = frame_count_q[10:8];
    assign scratch_word     = {1'b0, scratch_q[14:0]};
    assign frame_word       = {5'h00, frame_count_high, frame_count_low};
    assign res.rd_ep        = sel_ep_q;
    assign res.rd_take      = data_rd && reads_ok && (phase_q == udg_pkg::PH_RESULT);

    function automatic logic [15:0] pick(input logic wide, input logic hi, input logic [15:0] w);
        logic [15:0] r;
        r = w;
        if (!wide) begin
            r = hi ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
        end
        return r;
    endfunction

    always_comb begin
        rd_word = 16'h0000;
        case (phase_q)
            udg_pkg::PH_RESULT: rd_word = {8'h00, res.rd_byte};
            udg_pkg::PH_SCR_RD: rd_word = pick(bus_wide, byte_idx_q, scratch_word);
            udg_pkg::PH_FRAME:  rd_word = pick(bus_wide, byte_idx_q, frame_word);
            default:            rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_dout       <= 16'h0000;
            bus_dout_valid <= 1'b0;
        end else begin
            bus_dout_valid <= data_rd;
            if (data_rd) begin
                bus_dout <= reads_ok ? rd_word : 16'h0000;
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/udg_pkg.sv
// constants and types shared by the general command register block
`default_nettype none
package udg_pkg;
    // ------------------------------------------------------------
    // counts and widths
    // ------------------------------------------------------------
    localparam int unsigned EP_COUNT  = 16;
    localparam int unsigned EP_BITS   = 4;
    localparam int unsigned CODE_BITS = 4;
    localparam int unsigned FRAME_W   = 11;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_RESULT_HI = 4'hA;
    localparam logic [7:0] CMD_UNLOCK    = 8'hB0;
    localparam logic [7:0] CMD_SCR_WR    = 8'hB2;
    localparam logic [7:0] CMD_SCR_RD    = 8'hB3;
    localparam logic [7:0] CMD_FRAME_RD  = 8'hB4;

    // ------------------------------------------------------------
    // key and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] WAKE_KEY     = 16'hAA37;
    localparam logic [15:0] SCRATCH_RST  = 16'h0000;
    localparam logic [10:0] FRAME_RST    = 11'h000;
    localparam logic [7:0]  RESULT_RST   = 8'h00;
    localparam logic        LOCK_RST     = 1'b0;

    // ------------------------------------------------------------
    // result byte and scratch field positions
    // ------------------------------------------------------------
    localparam int unsigned RES_OK_BIT      = 0;
    localparam int unsigned RES_CODE_LSB    = 1;
    localparam int unsigned RES_TOGGLE_BIT  = 6;
    localparam int unsigned RES_OVERRUN_BIT = 7;
    localparam int unsigned SCR_TOP_BIT     = 15;

    // ------------------------------------------------------------
    // fault codes
    // ------------------------------------------------------------
    localparam logic [3:0] F_NONE       = 4'h0;
    localparam logic [3:0] F_PID_ENC    = 4'h1;
    localparam logic [3:0] F_PID_UNK    = 4'h2;
    localparam logic [3:0] F_UNEXPECTED = 4'h3;
    localparam logic [3:0] F_TOKEN_CRC  = 4'h4;
    localparam logic [3:0] F_DATA_CRC   = 4'h5;
    localparam logic [3:0] F_TIMEOUT    = 4'h6;
    localparam logic [3:0] F_BABBLE     = 4'h7;
    localparam logic [3:0] F_EOP        = 4'h8;
    localparam logic [3:0] F_NAK        = 4'h9;
    localparam logic [3:0] F_STALL      = 4'hA;
    localparam logic [3:0] F_OVERFLOW   = 4'hB;
    localparam logic [3:0] F_EMPTY_ISO  = 4'hC;
    localparam logic [3:0] F_STUFF      = 4'hD;
    localparam logic [3:0] F_SYNC       = 4'hE;
    localparam logic [3:0] F_TOGGLE     = 4'hF;
    // the only packet type nibble that names nothing
    localparam logic [3:0] PID_UNDEFINED = 4'h0;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_RESULT,
        PH_UNLOCK,
        PH_SCR_WR,
        PH_SCR_RD,
        PH_FRAME,
        PH_IGNORE
    } udg_phase_type;
endpackage
`default_nettype wire

// >>> rtl/udg_res_if.sv
// carrier between the command decoder and the per-endpoint result store
`default_nettype none
interface udg_res_if;
    logic       ev_valid;
    logic [3:0] ev_ep;
    logic [3:0] ev_code;
    logic       ev_ok;
    logic       ev_toggle;
    logic       rd_take;
    logic [3:0] rd_ep;
    logic [7:0] rd_byte;

    modport store (
        input  ev_valid,
        input  ev_ep,
        input  ev_code,
        input  ev_ok,
        input  ev_toggle,
        input  rd_take,
        input  rd_ep,
        output rd_byte
    );
    modport ctrl (
        output ev_valid,
        output ev_ep,
        output ev_code,
        output ev_ok,
        output ev_toggle,
        output rd_take,
        output rd_ep,
        input  rd_byte
    );
endinterface
`default_nettype wire

// >>> rtl/udg_result_store.sv
// per-endpoint transaction result bytes with overrun tracking
`default_nettype none
module udg_result_store (
    input  wire logic clk,
    input  wire logic rst_n,
    udg_res_if.store  res
);
    logic [7:0] result_q [udg_pkg::EP_COUNT];
    logic       result_overrun_flag_q [udg_pkg::EP_COUNT];

    assign res.rd_byte = result_q[res.rd_ep];

    // ------------------------------------------------------------
    // one result byte per endpoint
    // ------------------------------------------------------------
    for (genvar i = 0; i < udg_pkg::EP_COUNT; i++) begin : g_ep
        logic hit_ev;
        logic hit_rd;
        assign hit_ev = res.ev_valid && (res.ev_ep == 4'(i));
        assign hit_rd = res.rd_take && (res.rd_ep == 4'(i));

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                result_q[i] <= udg_pkg::RESULT_RST;
                result_overrun_flag_q[i] <= 1'b0;
            end else if (hit_ev) begin
                // a read in the same cycle consumes the old byte, so no overrun
                result_q[i][udg_pkg::RES_OVERRUN_BIT] <= result_overrun_flag_q[i] && !hit_rd;
                if (res.ev_ok) begin
                    result_q[i][udg_pkg::RES_TOGGLE_BIT] <= res.ev_toggle;
                end
                result_q[i][5] <= 1'b0;
                result_q[i][4:1] <= res.ev_code;
                result_q[i][udg_pkg::RES_OK_BIT] <= res.ev_ok;
                result_overrun_flag_q[i] <= 1'b1;
            end else if (hit_rd) begin
                result_q[i][udg_pkg::RES_OVERRUN_BIT] <= 1'b0;
                result_overrun_flag_q[i] <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/udg_general_cmd_regs_assertions.sv
// port-level assertions for the general command register block
`default_nettype none
module udg_cmd_regs_chk (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        cmd_data_select,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [15:0] bus_dout,
    input wire logic        bus_dout_valid,
    input wire logic        usb_suspend,
    input wire logic        txn_done,
    input wire logic        evt_toggle_bad,
    input wire logic        regs_locked,
    input wire logic        fifo_write_en,
    input wire logic        payload_discard
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    property p_rd_valid;
        bus_rd && !cmd_data_select |=> bus_dout_valid;
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("no valid after read");
    property p_no_valid;
        !(bus_rd && !cmd_data_select) |=> !bus_dout_valid;
    endproperty
    a_no_valid: assert property (p_no_valid) else $error("valid without read");
    property p_dout_hold;
        !bus_dout_valid |-> $stable(bus_dout);
    endproperty
    a_dout_hold: assert property (p_dout_hold) else $error("read data moved");
    property p_susp_lock;
        usb_suspend |-> ##2 regs_locked;
    endproperty
    a_susp_lock: assert property (p_susp_lock) else $error("suspend did not lock");
    property p_susp_fifo;
        usb_suspend |=> !fifo_write_en;
    endproperty
    a_susp_fifo: assert property (p_susp_fifo) else $error("fifo writable in suspend");
    property p_discard;
        payload_discard |-> $past(txn_done) && $past(evt_toggle_bad);
    endproperty
    a_discard: assert property (p_discard) else $error("discard without bad toggle");
    property p_unlock;
        $fell(regs_locked) |-> $past(bus_wr, 2) && !$past(cmd_data_select, 2);
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock without key write");
    property p_locked_rd;
        usb_suspend && $past(usb_suspend) && bus_rd && !cmd_data_select |=> bus_dout == 16'h0000;
    endproperty
    a_locked_rd: assert property (p_locked_rd) else $error("locked read not zero");
    c_unlock: cover property ($fell(regs_locked));
    c_discard: cover property (payload_discard);
    c_locked_read: cover property (usb_suspend && bus_rd);
endmodule
bind udg_general_cmd_regs udg_cmd_regs_chk udg_cmd_regs_chk_i (.*);
`default_nettype wire

// >>> bench/udg_host_model.sv
// host controller model on the command and data port
`default_nettype none
module udg_host_model (
    input  wire logic        clk,
    output logic             cmd_data_select,
    output logic             bus_wr,
    output logic             bus_rd,
    output logic             bus_wide,
    output logic      [15:0] bus_din,
    input  wire logic [15:0] bus_dout,
    input  wire logic        bus_dout_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cmd_data_select, bus_wr, bus_rd, bus_wide, bus_din} = '0;
    end
    // released data lines flip so a stale value is never mistaken for a fresh one
    task automatic op(input logic s, input logic w, input logic r, input logic [15:0] d);
        @(posedge clk);
        #1;
        {cmd_data_select, bus_wr, bus_rd, bus_din} = {s, w, r, d};
        @(posedge clk);
        #1;
        {cmd_data_select, bus_wr, bus_rd, bus_din} = {3'b000, ~d};
    endtask
    task automatic cmd(input logic [7:0] c);
        op(1'b1, 1'b1, 1'b0, {8'hFF, c});
    endtask
    task automatic wr(input logic [15:0] d);
        op(1'b0, 1'b1, 1'b0, d);
    endtask
    task automatic rd(output logic [15:0] v, output logic ok);
        op(1'b0, 1'b0, 1'b1, 16'h0000);
        v = bus_dout;
        ok = bus_dout_valid;
    endtask
endmodule
`default_nettype wire

// >>> bench/udg_general_cmd_regs_tb_top.sv
// self-checking bench for the general command register block
`default_nettype none
module udg_general_cmd_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn, cmd_data_select, bus_wr, bus_rd, bus_wide, bus_dout_valid, ok;
    logic usb_suspend, usb_bus_reset, sof_valid, txn_done, txn_control_ep, txn_iso;
    logic txn_data_moved, txn_toggle, txn_pid_seen, regs_locked, fifo_write_en, payload_discard;
    logic err_token_crc, err_data_crc, err_timeout, err_babble, err_eop, err_stuff, err_sync;
    logic evt_nak, evt_stall, evt_overflow, evt_unexpected, evt_setup, evt_empty_tx;
    logic evt_toggle_bad;
    logic [15:0] bus_din, bus_dout, v;
    logic [13:0] ev;
    logic [10:0] sof_frame;
    logic [7:0]  txn_pid;
    logic [3:0]  txn_ep;
    int          failures, checks;
    logic [3:0]  codes [16] = '{4'hE, 4'hD, 4'h4, 4'h5, 4'h8, 4'h7, 4'hB, 4'h3,
                                4'hF, 4'h6, 4'hA, 4'h9, 4'hC, 4'h3, 4'h1, 4'h2};
    assign {evt_setup, evt_empty_tx, evt_nak, evt_stall, err_timeout, evt_toggle_bad,
            evt_unexpected, evt_overflow, err_babble, err_eop, err_data_crc, err_token_crc,
            err_stuff, err_sync} = ev;
    udg_general_cmd_regs udg_general_cmd_regs_i (.*);
    udg_host_model udg_host_model_i (.*);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ------------------------------------------------------------
    // port tasks and verdict
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h got %h", n, e, g);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        udg_host_model_i.cmd(c);
    endtask
    task automatic wr(input logic [15:0] d);
        udg_host_model_i.wr(d);
    endtask
    task automatic rdchk(input string n, input logic [15:0] e);
        udg_host_model_i.rd(v, ok);
        chk(n, e, v);
        chk("read valid", 16'h0001, {15'h0000, ok});
    endtask
    task automatic txn(input logic [3:0] ep, input logic [13:0] e, input logic [8:0] p);
        @(posedge clk);
        #1;
        {txn_done, txn_ep, ev, txn_pid_seen, txn_pid} = {1'b1, ep, e, p};
        @(posedge clk);
        #1;
        {txn_done, ev, txn_pid_seen, txn_data_moved} = '0;
    endtask
    task automatic sof(input logic [10:0] f);
        @(posedge clk);
        #1;
        {sof_valid, sof_frame} = {1'b1, f};
        @(posedge clk);
        #1;
        sof_valid = 1'b0;
    endtask
    task automatic unlock(input logic [15:0] k);
        cmd(udg_pkg::CMD_UNLOCK);
        wr({8'h00, k[7:0]});
        wr({8'h00, k[15:8]});
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        end_of_test();
    end
    initial begin
        {resetn, usb_suspend, usb_bus_reset, sof_valid, txn_done, txn_control_ep} = '0;
        {txn_data_moved, txn_pid_seen, txn_pid, txn_ep, sof_frame, ev} = '0;
        {txn_iso, txn_toggle} = 2'b11;
        failures = 0;
        checks = 0;
        repeat (12) @(posedge clk);
        #1;
        resetn = 1'b1;
        repeat (3) @(posedge clk);
        cmd(udg_pkg::CMD_SCR_RD);
        rdchk("scratch low", 16'h0000);
        rdchk("scratch high", 16'h0000);
        cmd(udg_pkg::CMD_SCR_WR);
        wr(16'hFFA5);
        wr(16'hFF7F);
        cmd(udg_pkg::CMD_SCR_RD);
        rdchk("scratch low", 16'h00A5);
        rdchk("scratch high", 16'h007F);
        udg_host_model_i.bus_wide = 1'b1;
        cmd(udg_pkg::CMD_SCR_WR);
        wr(16'h2C3D);
        cmd(udg_pkg::CMD_SCR_RD);
        rdchk("scratch word", 16'h2C3D);
        sof(11'h7FF);
        cmd(udg_pkg::CMD_FRAME_RD);
        rdchk("frame word", 16'h07FF);
        udg_host_model_i.bus_wide = 1'b0;
        sof(11'h5A3);
        cmd(udg_pkg::CMD_FRAME_RD);
        rdchk("frame low", 16'h00A3);
        rdchk("frame high", 16'h0005);
        txn_data_moved = 1'b1;
        txn(4'h3, 14'h0000, 9'h000);
        cmd(8'hA3);
        rdchk("result ok", 16'h0041);
        for (int i = 0; i < 16; i++) begin
            txn(4'h5, (i < 14) ? 14'(1 << i) : 14'h0000, (i == 14) ? 9'h112 : {i == 15, 8'hF0});
            chk("discard", {15'h0000, i == 8}, {15'h0000, payload_discard});
            cmd(8'hA5);
            rdchk("fault code", {11'h000, codes[i], 1'b0});
        end
        txn(4'h5, 14'h0800, 9'h000);
        txn(4'h5, 14'h0800, 9'h000);
        cmd(8'hA5);
        rdchk("overrun", 16'h0092);
        {txn_data_moved, txn_toggle, txn_control_ep, txn_iso} = 4'hA;
        txn(4'h3, 14'h3000, 9'h000);
        cmd(8'hA3);
        rdchk("data0 setup", 16'h0001);
        cmd(udg_pkg::CMD_SCR_RD);
        usb_bus_reset = 1'b1;
        @(posedge clk);
        #1;
        usb_bus_reset = 1'b0;
        rdchk("aborted read", 16'h0000);
        usb_suspend = 1'b1;
        cmd(udg_pkg::CMD_SCR_WR);
        wr(16'h0000);
        wr(16'h0000);
        chk("locked", 16'h0001, {15'h0000, regs_locked});
        chk("fifo write", 16'h0000, {15'h0000, fifo_write_en});
        rdchk("suspended read", 16'h0000);
        usb_suspend = 1'b0;
        unlock(16'hAB37);
        chk("locked", 16'h0001, {15'h0000, regs_locked});
        cmd(udg_pkg::CMD_SCR_RD);
        rdchk("locked read", 16'h0000);
        unlock(udg_pkg::WAKE_KEY);
        chk("unlocked", 16'h0000, {15'h0000, regs_locked});
        chk("fifo write", 16'h0001, {15'h0000, fifo_write_en});
        cmd(udg_pkg::CMD_SCR_RD);
        rdchk("scratch low", 16'h003D);
        rdchk("scratch high", 16'h002C);
        usb_suspend = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        usb_suspend = 1'b0;
        chk("relocked", 16'h0001, {15'h0000, regs_locked});
        udg_host_model_i.bus_wide = 1'b1;
        cmd(udg_pkg::CMD_UNLOCK);
        wr(udg_pkg::WAKE_KEY);
        repeat (2) @(posedge clk);
        #1;
        chk("wide unlock", 16'h0000, {15'h0000, regs_locked});
        end_of_test();
    end
endmodule
`default_nettype wire
